// ===== rtl/pwr_rst_device.sv
// Purpose: Device end: power-mode registers, input gating, reset sequence
// Assumes: Link inputs synchronous to I_CLK; host keeps its own rules
// Notes:   Logic array behaviour is modelled at cycle level only
`default_nettype none
module pwr_rst_device
   import pwr_rst_pkg::*;
#(
   parameter int unsigned WAIT_CYC  = POST_RESET_WAIT_CYC,
   parameter int unsigned QUIET_LEN = QUIET_CYC
) (
   input  wire logic     I_CLK,
   input  wire logic     I_RST_N,
   pwr_rst_if.device     link,
   input  wire logic     I_POWER_DOWN,
   input  wire logic     I_MCELL_RESET,
   input  wire logic     I_MCELL_PRESET,
   input  wire logic [7:0] I_PORT_OUT,
   input  wire logic [7:0] I_PORT_DIR,
   output logic [4:0]    O_ARRAY_INPUTS,
   output logic          O_ARRAY_CLK,
   output logic          O_MCELL_CLK,
   output logic          O_ARRAY_STANDBY,
   output logic          O_SLOW_DELAY,
   output logic          O_FLASH_ENABLE,
   output logic          O_FLASH_WR_N,
   output logic          O_FLASH_RD_N,
   output logic          O_READ_ARRAY_MODE,
   output logic [7:0]    O_PORT_DIR,
   output logic [7:0]    O_PORT_OUT,
   output logic          O_MCELL_Q,
   output logic          O_LOGIC_VALID,
   output logic          O_ADDR_BLOCKED
);
   import pwr_rst_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      rst_state_t  phase;
      logic [15:0] cnt;
      logic [7:0]  reg_a;
      logic [7:0]  reg_b;
      logic        powered;
      logic        cfg_loaded;
      logic [7:0]  quiet;
      logic [7:0]  rate;
      logic [4:0]  arr_in;
      logic        arr_clk;
      logic        mcell_clk;
      logic        standby;
      logic        slow;
      logic        fl_en;
      logic        fl_wr_n;
      logic        fl_rd_n;
      logic        read_array;
      logic [7:0]  port_dir;
      logic [7:0]  port_out;
      logic        mcell_q;
      logic        valid;
      logic        addr_blk;
      logic        ready;
   } dev_state_t;

   dev_state_t s_r;
   dev_state_t s_nxt;
   logic       in_reset;

   assign in_reset = (s_r.phase != RS_RUN);

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [4:0] ins;
      logic       change;
      logic       mclk_rise;
      ins = {link.port_c_pin7, link.port_d_pin0, link.control_input_2,
         link.rd_n, link.wr_n};
      change = 1'b0;
      // Macrocell flops move on the rising edge of their gated clock only
      mclk_rise = link.logic_clock_input
         & ~s_r.reg_a[CLK_MCELL_BLOCK_BIT] & ~s_r.mcell_clk;
      s_nxt = s_r;
      // Reset sequencer
      case (s_r.phase)
         RS_RUN: begin
            if (!link.reset_n) begin
               s_nxt.phase = RS_RESET;
            end
         end
         RS_RESET: begin
            s_nxt.cnt = '0;
            if (link.reset_n) begin
               s_nxt.phase = RS_WAIT;
            end
         end
         default: begin
            if (!link.reset_n) begin
               s_nxt.phase = RS_RESET;
            end else if (s_r.cnt >= 16'(WAIT_CYC - 1)) begin
               s_nxt.phase = RS_RUN;
            end else begin
               s_nxt.cnt = s_r.cnt + 16'h0001;
            end
         end
      endcase
      s_nxt.ready = (s_nxt.phase == RS_RUN);
      if (!link.reset_n) begin
         // Cleared by any reset, kept in power-down                 
         s_nxt.port_dir = 8'h00;
         s_nxt.port_out = 8'h00;
         if (!s_r.powered) begin
            s_nxt.reg_a = PWR_REG_RESET;
            s_nxt.reg_b = PWR_REG_RESET;
            s_nxt.mcell_q = 1'b0;
            s_nxt.cfg_loaded = 1'b1;
            s_nxt.read_array = 1'b1;
            s_nxt.valid = 1'b0;
         end else begin
            s_nxt.mcell_q = I_MCELL_PRESET | (s_r.mcell_q
               & ~I_MCELL_RESET);
         end
      end else begin
         if (link.power_good && s_r.cfg_loaded) begin
            s_nxt.powered = 1'b1;
            s_nxt.valid = 1'b1;
         end
         if (!I_POWER_DOWN && !in_reset) begin
            s_nxt.port_dir = I_PORT_DIR;
            s_nxt.port_out = I_PORT_OUT;
         end
         if (I_POWER_DOWN) begin
            s_nxt.mcell_q = I_MCELL_PRESET | (s_r.mcell_q
               & ~I_MCELL_RESET);
         end else if (mclk_rise) begin
            s_nxt.mcell_q = ~s_r.mcell_q;
         end
      end
      if (!link.power_good) begin
         s_nxt.powered = 1'b0;
         s_nxt.cfg_loaded = 1'b0;
      end
      // Register writes through the device port, taken in run only
      if (!in_reset && link.reset_n) begin
         if (link.cmd == CMD_WR_A) begin
            s_nxt.reg_a = link.cmd_data & REG_A_USED_MASK;
         end else if (link.cmd == CMD_WR_B) begin
            s_nxt.reg_b = link.cmd_data & REG_B_USED_MASK;
         end
      end
      // Input gating into the array
      for (int i = 0; i < BLOCK_W; i++) begin
         s_nxt.arr_in[i] = ins[i] & ~s_r.reg_b[BLOCK_LSB + i];
      end
      s_nxt.arr_clk = link.logic_clock_input
         & ~s_r.reg_a[CLK_ARRAY_BLOCK_BIT];
      s_nxt.mcell_clk = link.logic_clock_input
         & ~s_r.reg_a[CLK_MCELL_BLOCK_BIT];
      // Standby tracking
      change = (s_nxt.arr_in != s_r.arr_in) | (s_nxt.arr_clk
         != s_r.arr_clk);
      if (!s_r.reg_a[FULL_SPEED_OFF_BIT] || change) begin
         s_nxt.quiet = '0;
         s_nxt.standby = 1'b0;
      end else if (s_r.quiet >= 8'(QUIET_LEN - 1)) begin
         s_nxt.standby = 1'b1;
      end else begin
         s_nxt.quiet = s_r.quiet + 8'h01;
      end
      // Composite rate estimate: slow when changes are spaced apart
      if (change) begin
         s_nxt.rate = '0;
      end else if (s_r.rate != 8'hff) begin
         s_nxt.rate = s_r.rate + 8'h01;
      end
      s_nxt.slow = s_r.reg_a[FULL_SPEED_OFF_BIT]
         && (s_r.rate >= 8'(SLOW_RATE_CYC));
      // Flash path: strobes bypass the gating bits
      s_nxt.fl_wr_n = link.wr_n;
      s_nxt.fl_rd_n = link.rd_n;
      s_nxt.fl_en = !link.chip_select_n && !in_reset;
      s_nxt.addr_blk = I_POWER_DOWN;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         s_r <= '0;
         s_r.phase <= RS_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.reg_a_rd     = s_r.reg_a;
   assign link.reg_b_rd     = s_r.reg_b;
   assign link.dev_ready    = s_r.ready;
   assign O_ARRAY_INPUTS    = s_r.arr_in;
   assign O_ARRAY_CLK       = s_r.arr_clk;
   assign O_MCELL_CLK       = s_r.mcell_clk;
   assign O_ARRAY_STANDBY   = s_r.standby;
   assign O_SLOW_DELAY      = s_r.slow;
   assign O_FLASH_ENABLE    = s_r.fl_en;
   assign O_FLASH_WR_N      = s_r.fl_wr_n;
   assign O_FLASH_RD_N      = s_r.fl_rd_n;
   assign O_READ_ARRAY_MODE = s_r.read_array;
   assign O_PORT_DIR        = s_r.port_dir;
   assign O_PORT_OUT        = s_r.port_out;
   assign O_MCELL_Q         = s_r.mcell_q;
   assign O_LOGIC_VALID     = s_r.valid;
   assign O_ADDR_BLOCKED    = s_r.addr_blk;
endmodule : pwr_rst_device
`default_nettype wire

// ===== rtl/pwr_rst_pkg.sv
// Purpose: Shared constants and types for the power and reset controller
// Assumes: One 25 MHz clock, synchronous active-low reset
// Notes:   Both ends and the interface import this package
`default_nettype none
package pwr_rst_pkg;
   localparam int unsigned CLK_MHZ          = 25;
   // Times in ns as specified
   localparam int unsigned QUIET_NS         = 100;
   localparam int unsigned SLOW_EXTRA_NS    = 10;
   localparam int unsigned SLOW_RATE_MHZ    = 10;
   localparam int unsigned QUIET_CYC        = (QUIET_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SLOW_EXTRA_CYC   =
      ((SLOW_EXTRA_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
      (SLOW_EXTRA_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SLOW_RATE_CYC    = CLK_MHZ / SLOW_RATE_MHZ;
   // Default wait figures (arbitrary plain defaults)
   localparam int unsigned POST_RESET_WAIT_CYC   = 8;
   localparam int unsigned POWERON_PULSE_CYC     = 16;
   localparam int unsigned WARM_PULSE_CYC        = 2;
   // Power-mode register A fields
   localparam int unsigned FULL_SPEED_OFF_BIT    = 3;
   localparam int unsigned CLK_ARRAY_BLOCK_BIT   = 4;
   localparam int unsigned CLK_MCELL_BLOCK_BIT   = 5;
   // Power-mode register B fields: bit 2..6 block ctl0,1,2,pd0,pc7
   localparam int unsigned BLOCK_LSB             = 2;
   localparam int unsigned BLOCK_W               = 5;
   localparam logic [7:0]  REG_B_USED_MASK       = 8'h7c;
   localparam logic [7:0]  REG_A_USED_MASK       = 8'h38;
   localparam logic [7:0]  PWR_REG_RESET         = 8'h00;
   // Wishbone register word offsets (byte addresses)
   localparam logic [3:0]  OFF_REG_A             = 4'h0;
   localparam logic [3:0]  OFF_REG_B             = 4'h4;
   localparam logic [3:0]  OFF_STATUS            = 4'h8;
   localparam logic [3:0]  OFF_CTRL              = 4'hc;
   // Control register bits
   localparam int unsigned CTRL_PON_BIT          = 0;
   localparam int unsigned CTRL_WARM_BIT         = 1;
   // Device-port command codes
   typedef enum logic [1:0] {CMD_NONE, CMD_WR_A, CMD_WR_B} cmd_t;
   typedef enum {RS_RUN, RS_RESET, RS_WAIT} rst_state_t;
   typedef enum {H_IDLE, H_PULSE, H_WAIT} host_state_t;
endpackage : pwr_rst_pkg
`default_nettype wire

// ===== rtl/pwr_rst_if.sv
// Purpose: Link between the host sequencer and the device controller
// Assumes: Single clock shared by both ends
// Notes:   No tri-state wires; all signals are one-way
`default_nettype none
interface pwr_rst_if;
   import pwr_rst_pkg::*;
   logic       power_good;     // Supply steady, first reset is power-on
   logic       reset_n;        // Active-low reset to the device
   logic       chip_select_n;  // Flash and I/O block select
   logic       wr_n;           // Write strobe, control_input_0
   logic       rd_n;           // Read strobe, control_input_1
   logic       control_input_2;
   logic       port_d_pin0;
   logic       port_c_pin7;
   logic       logic_clock_input;
   logic [7:0] flash_sector_selects;
   cmd_t       cmd;            // Power-mode register write, one cycle
   logic [7:0] cmd_data;
   logic [7:0] reg_a_rd;
   logic [7:0] reg_b_rd;
   logic       dev_ready;      // Device out of reset and wait period
   modport host (output power_good, reset_n, chip_select_n, wr_n, rd_n,
      control_input_2, port_d_pin0, port_c_pin7, logic_clock_input,
      flash_sector_selects, cmd, cmd_data,
      input reg_a_rd, reg_b_rd, dev_ready);
   modport device (input power_good, reset_n, chip_select_n, wr_n, rd_n,
      control_input_2, port_d_pin0, port_c_pin7, logic_clock_input,
      flash_sector_selects, cmd, cmd_data,
      output reg_a_rd, reg_b_rd, dev_ready);
endinterface : pwr_rst_if
`default_nettype wire

// ===== rtl/pwr_rst_host.sv
// Purpose: Host end: Wishbone slave registers driving the device link
// Assumes: Classic Wishbone, 32-bit data, single clock
// Notes:   Ack one cycle after request; unmapped reads return zero
`default_nettype none
module pwr_rst_host
   import pwr_rst_pkg::*;
#(
   parameter int unsigned PON_CYC  = POWERON_PULSE_CYC,
   parameter int unsigned WARM_CYC = WARM_PULSE_CYC,
   parameter int unsigned WAIT_CYC = POST_RESET_WAIT_CYC
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   pwr_rst_if.host          link,
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [3:0]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   output logic [31:0]      O_WB_DAT,
   output logic             O_WB_ACK,
   input  wire logic [7:0]  I_STROBES
);
   import pwr_rst_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      host_state_t phase;
      logic [15:0] cnt;
      logic        pon_done;
      logic        rst_n;
      logic        pg;
      logic        busy;
      cmd_t        cmd;
      logic [7:0]  cmd_data;
      logic [7:0]  strobes;
      logic [31:0] rdat;
      logic        ack;
   } host_state_s_t;

   host_state_s_t s_r;
   host_state_s_t s_nxt;
   logic          req;

   assign req = I_WB_CYC && I_WB_STB && !s_r.ack;

   always_comb begin
      s_nxt = s_r;
      s_nxt.cmd = CMD_NONE;
      s_nxt.ack = 1'b0;
      s_nxt.pg = 1'b1;
      s_nxt.strobes = I_STROBES;
      case (s_r.phase)
         H_IDLE: begin
            s_nxt.busy = 1'b0;
            if (!s_r.pon_done) begin
               s_nxt.phase = H_PULSE;
               s_nxt.rst_n = 1'b0;
               s_nxt.cnt = 16'(PON_CYC);
               s_nxt.busy = 1'b1;
            end
         end
         H_PULSE: begin
            if (s_r.cnt <= 16'h0001) begin
               s_nxt.rst_n = 1'b1;
               s_nxt.pon_done = 1'b1;
               s_nxt.phase = H_WAIT;
               s_nxt.cnt = 16'(WAIT_CYC + 1);
            end else begin
               s_nxt.cnt = s_r.cnt - 16'h0001;
            end
         end
         default: begin
            if (s_r.cnt == 16'h0000 && link.dev_ready) begin
               s_nxt.phase = H_IDLE;
               s_nxt.busy = 1'b0;
            end else if (s_r.cnt != 16'h0000) begin
               s_nxt.cnt = s_r.cnt - 16'h0001;
            end
         end
      endcase
      if (req) begin
         s_nxt.ack = 1'b1;
         s_nxt.rdat = 32'h0;
         if (I_WB_ADR == OFF_REG_A) begin
            s_nxt.rdat = {24'h0, link.reg_a_rd};
            if (I_WB_WE && I_WB_SEL[0] && !s_r.busy) begin
               s_nxt.cmd = CMD_WR_A;
               s_nxt.cmd_data = I_WB_DAT[7:0];
            end
         end else if (I_WB_ADR == OFF_REG_B) begin
            s_nxt.rdat = {24'h0, link.reg_b_rd};
            if (I_WB_WE && I_WB_SEL[0] && !s_r.busy) begin
               s_nxt.cmd = CMD_WR_B;
               s_nxt.cmd_data = I_WB_DAT[7:0] & REG_B_USED_MASK;
            end
         end else if (I_WB_ADR == OFF_STATUS) begin
            s_nxt.rdat = {30'h0, s_r.busy, link.dev_ready};
         end else if (I_WB_ADR == OFF_CTRL) begin
            if (I_WB_WE && I_WB_SEL[0] && !s_r.busy) begin
               if (I_WB_DAT[CTRL_WARM_BIT]) begin
                  s_nxt.phase = H_PULSE;
                  s_nxt.rst_n = 1'b0;
                  s_nxt.cnt = 16'(WARM_CYC);
                  s_nxt.busy = 1'b1;
               end
               if (I_WB_DAT[CTRL_PON_BIT]) begin
                  s_nxt.pon_done = 1'b0;
                  s_nxt.pg = 1'b0;
               end
            end
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         s_r <= '0;
         s_r.rst_n <= 1'b0;
         s_r.busy <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // During the power-on pulse sectors stay low and write stays high
   assign link.power_good           = s_r.pg;
   assign link.reset_n              = s_r.rst_n;
   assign link.chip_select_n        = s_r.busy;
   assign link.wr_n                 = s_r.busy | s_r.strobes[0];
   assign link.rd_n                 = s_r.busy | s_r.strobes[1];
   assign link.control_input_2      = s_r.strobes[2];
   assign link.port_d_pin0          = s_r.strobes[3];
   assign link.port_c_pin7          = s_r.strobes[4];
   assign link.logic_clock_input    = s_r.strobes[5];
   assign link.flash_sector_selects = 8'h00;
   assign link.cmd                  = s_r.cmd;
   assign link.cmd_data             = s_r.cmd_data;
   assign O_WB_DAT                  = s_r.rdat;
   assign O_WB_ACK                  = s_r.ack;
endmodule : pwr_rst_host
`default_nettype wire

// ===== bench/pwr_rst_link_asserts.sv
// Purpose: Assertions on the link between host end and device end
// Assumes: One clock; default post-reset wait of 8 cycles
// Notes:   Takes the link signals as plain inputs, no bind
`default_nettype none
module pwr_rst_link_asserts
   import pwr_rst_pkg::*;
(
   input wire logic              I_CLK,
   input wire logic              I_RST_N,
   input wire logic              power_good,
   input wire logic              reset_n,
   input wire logic              chip_select_n,
   input wire logic              wr_n,
   input wire logic              rd_n,
   input wire logic [7:0]        flash_sector_selects,
   input wire pwr_rst_pkg::cmd_t cmd,
   input wire logic [7:0]        cmd_data,
   input wire logic [7:0]        reg_a_rd,
   input wire logic [7:0]        reg_b_rd,
   input wire logic              dev_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);
////////////////////////////////////////////////////////////
   property p_por_quiet;
      !reset_n |-> flash_sector_selects == 8'h00 && wr_n;
   endproperty
   a_por_quiet: assert property (p_por_quiet)
      else $error("sector select or write strobe active in reset");
   property p_ready_off;
      !reset_n |=> !dev_ready;
   endproperty
   a_ready_off: assert property (p_ready_off)
      else $error("device ready while reset held");
   // The repeat count is the default wait; the bench keeps it
   property p_wait;
      $rose(reset_n) |-> (!dev_ready) [*8] ##[1:4] dev_ready;
   endproperty
   a_wait: assert property (p_wait)
      else $error("post-reset wait length wrong");
   property p_no_early;
      !dev_ready |-> wr_n && rd_n && chip_select_n;
   endproperty
   a_no_early: assert property (p_no_early)
      else $error("access started before device ready");
   property p_upd_a;
      dev_ready && cmd == CMD_WR_A |=>
         reg_a_rd == ($past(cmd_data) & REG_A_USED_MASK);
   endproperty
   a_upd_a: assert property (p_upd_a)
      else $error("mode register A not updated next cycle");
   property p_upd_b;
      dev_ready && cmd == CMD_WR_B |=>
         reg_b_rd == ($past(cmd_data) & REG_B_USED_MASK);
   endproperty
   a_upd_b: assert property (p_upd_b)
      else $error("mode register B not updated next cycle");
   property p_unused;
      (reg_a_rd & ~REG_A_USED_MASK) == 8'h00 &&
         (reg_b_rd & ~REG_B_USED_MASK) == 8'h00;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused mode bit set");
   property p_keep;
      dev_ready && reset_n && power_good && cmd == CMD_NONE |=>
         $stable(reg_a_rd) && $stable(reg_b_rd);
   endproperty
   a_keep: assert property (p_keep)
      else $error("mode register changed without a write");
   property p_pon_clear;
      !power_good |-> ##[1:24] (reg_a_rd == 8'h00 && reg_b_rd == 8'h00);
   endproperty
   a_pon_clear: assert property (p_pon_clear)
      else $error("mode registers not cleared at power-on");
endmodule : pwr_rst_link_asserts
`default_nettype wire

// ===== bench/pld_power_and_reset_control_bench.sv
// Purpose: Self-checking bench for the power and reset controller
// Assumes: Host and device joined by the link interface
// Notes:   Registers are reached only over classic Wishbone
`default_nettype none
module pld_power_and_reset_control_bench
   import pwr_rst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, cyc, stb, we, ack, pdn, mrst, mpre;
   logic        aclk, mclk, stby, slow, fen, fwr, frd, ram, mq, lv, ab;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat;
   logic [7:0]  strb, pout, pdir, pdo, poo;
   logic [4:0]  ain;
   int          err_total, checked;
   pwr_rst_if link ();
   pwr_rst_host u_pwr_rst_host (.I_CLK(clk), .I_RST_N(rst_n), .link(link),
      .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
      .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .I_STROBES(strb));
   pwr_rst_device u_pwr_rst_device (.I_CLK(clk), .I_RST_N(rst_n),
      .link(link), .I_POWER_DOWN(pdn), .I_MCELL_RESET(mrst),
      .I_MCELL_PRESET(mpre), .I_PORT_OUT(pout), .I_PORT_DIR(pdir),
      .O_ARRAY_INPUTS(ain), .O_ARRAY_CLK(aclk), .O_MCELL_CLK(mclk),
      .O_ARRAY_STANDBY(stby), .O_SLOW_DELAY(slow), .O_FLASH_ENABLE(fen),
      .O_FLASH_WR_N(fwr), .O_FLASH_RD_N(frd), .O_READ_ARRAY_MODE(ram),
      .O_PORT_DIR(pdo), .O_PORT_OUT(poo), .O_MCELL_Q(mq),
      .O_LOGIC_VALID(lv), .O_ADDR_BLOCKED(ab));
   pwr_rst_link_asserts u_pwr_rst_link_asserts (.I_CLK(clk),
      .I_RST_N(rst_n), .power_good(link.power_good),
      .reset_n(link.reset_n), .chip_select_n(link.chip_select_n),
      .wr_n(link.wr_n), .rd_n(link.rd_n), .cmd(link.cmd),
      .flash_sector_selects(link.flash_sector_selects),
      .cmd_data(link.cmd_data), .reg_a_rd(link.reg_a_rd),
      .reg_b_rd(link.reg_b_rd), .dev_ready(link.dev_ready));
////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Ack is sampled on the rising edge; data is taken and the request
   // dropped at that same edge
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      q = 32'h0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'h1;
      adr <= a;
      wdat <= d;
      repeat (40) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      if (ack !== 1'b1) begin
         err_total++;
         tally_and_finish();
      end else begin
         q = rdat;
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
         sel <= 4'h0;
      end
   endtask : wb
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, {24'h0, d}, q);
   endtask : wr
   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rc
   task automatic settle();
      logic [31:0] q;
      repeat (2) wb(1'b0, OFF_STATUS, 32'h0, q);
   endtask : settle
   task automatic wait_ready();
      logic [31:0] q;
      repeat (100) begin
         wb(1'b0, OFF_STATUS, 32'h0, q);
         if (q === 32'h1) return;
      end
      err_total++;
      tally_and_finish();
   endtask : wait_ready
   // Returns one cycle after reset is first seen low; the warm pulse is
   // short, so looking later would miss it
   task automatic wait_rst();
      repeat (20) begin
         @(negedge clk);
         if (link.reset_n === 1'b0) begin
            @(negedge clk);
            return;
         end
      end
      err_total++;
      tally_and_finish();
   endtask : wait_rst
   task automatic toggle_clk();
      repeat (8) begin
         @(posedge clk);
         strb[5] <= ~strb[5];
      end
      @(negedge clk);
   endtask : toggle_clk
////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {rst_n, cyc, stb, we, pdn, mrst, mpre} = 7'h00;
      adr = 4'h0;
      sel = 4'h0;
      wdat = 32'h0;
      strb = 8'h3f;
      pout = 8'h5a;
      pdir = 8'hff;
      err_total = 0;
      checked = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      wait_ready();
      rc(OFF_REG_A, 32'h0);
      rc(OFF_REG_B, 32'h0);
      chk(ram, 1'b1);
      chk(lv, 1'b1);
      chk({aclk, mclk}, 2'b11);
      chk(fen, 1'b1);
      wr(OFF_REG_A, 8'hff);
      rc(OFF_REG_A, 32'h38);
      settle();
      chk({aclk, mclk}, 2'b00);
      chk(stby, 1'b1);
      chk(slow, 1'b1);
      wr(OFF_REG_A, 8'h08);
      toggle_clk();
      chk(stby, 1'b0);
      wr(OFF_REG_A, 8'h18);
      settle();
      toggle_clk();
      chk(stby, 1'b1);
      wr(OFF_REG_A, 8'h00);
      settle();
      chk({stby, slow}, 2'b00);
      wr(OFF_REG_B, 8'hff);
      rc(OFF_REG_B, 32'h7c);
      for (int i = 0; i < 5; i++) begin
         wr(OFF_REG_B, 8'h01 << (i + 2));
         settle();
         chk(ain, 5'h1f & ~(5'h01 << i));
      end
      wr(OFF_REG_B, 8'h0c);
      strb <= 8'h3c;
      settle();
      chk({fwr, frd, ain[1:0]}, 4'h0);
      strb <= 8'h3f;
      pdn <= 1'b1;
      settle();
      chk({fwr, frd}, 2'b11);
      chk(ab, 1'b1);
      pdn <= 1'b0;
      wr(4'h2, 8'hff);
      rc(4'h2, 32'h0);
      rc(OFF_REG_B, 32'h0c);
      // Warm reset keeps both mode registers
      wr(OFF_REG_A, 8'h08);
      wr(OFF_REG_B, 8'h04);
      mpre <= 1'b1;
      chk({pdo, poo}, 16'hff5a);
      wr(OFF_CTRL, 8'h02);
      wait_rst();
      chk({pdo, poo}, 16'h0000);
      chk(mq, 1'b1);
      wait_ready();
      mpre <= 1'b0;
      rc(OFF_REG_A, 32'h08);
      rc(OFF_REG_B, 32'h04);
      wr(OFF_CTRL, 8'h01);
      wait_rst();
      chk({mq, fen}, 2'b00);
      wait_ready();
      rc(OFF_REG_A, 32'h0);
      rc(OFF_REG_B, 32'h0);
      chk(ram, 1'b1);
      tally_and_finish();
   end
endmodule : pld_power_and_reset_control_bench
`default_nettype wire
